// ===== core/vfd_scan_controller.sv
// Purpose: Serial-loaded multiplexed VFD scan controller with its word FIFO.
// Assumes: All pins are asynchronous to core_clk and are sampled through 3 flops.
// Notes: The oscillator pin paces the scan and the word decoder; it is sampled, not used as a clock.
`timescale 1ns/1ps
`include "vfd_scan_defs.svh"

// ----------------------------------------------------------------------------
// Word FIFO
// ----------------------------------------------------------------------------
module vfd_word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = `VFD_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_shape
    $error("fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_st_t;

  fifo_st_t st_r;
  fifo_st_t st_nxt;

  assign in_ready = (st_r.wp ^ st_r.rp) != {1'b1, {AW{1'b0}}};
  assign out_valid = st_r.wp != st_r.rp;
  assign out_data = st_r.mem[st_r.rp[AW-1:0]];

  always_comb begin
    st_nxt = st_r;
    if (in_valid && in_ready) begin
      st_nxt.mem[st_r.wp[AW-1:0]] = in_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    if (!rst_n) begin
      st_nxt.wp = '0;
      st_nxt.rp = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    st_r <= st_nxt;
  end
endmodule

// ----------------------------------------------------------------------------
// Scan controller
// ----------------------------------------------------------------------------
module vfd_scan_controller #(
  parameter int FIFO_DEPTH = `VFD_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reset_n_pin,
  input wire logic select_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  input wire logic osc_in_pin,
  output logic [15:0] segment_outputs,
  output logic [13:0] digit_outputs,
  output logic rx_overrun
);
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("word fifo needs at least two entries");
  end

  vfd_scan_pkg::vfd_st_t st_r;
  vfd_scan_pkg::vfd_st_t st_nxt;
  vfd_scan_pkg::pins_t pins_in;
  vfd_scan_pkg::word_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic osc_tick;
  logic pop;

  assign pins_in = '{reset_n: reset_n_pin, osc: osc_in_pin, sck: sck_pin,
                     si: si_pin, cs_n: select_n_pin};
  assign osc_tick = st_r.f.osc && !st_r.fp.osc;
  assign pop = fifo_out_valid && osc_tick;

  assign segment_outputs = st_r.seg;
  assign digit_outputs = st_r.dig;
  assign rx_overrun = st_r.overrun;

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  function automatic logic [3:0] duty_units(input logic [2:0] d);
    if (d == `VFD_DUTY_FULL) begin
      duty_units = `VFD_DUTY_FULL_UNITS;
    end else begin
      duty_units = 4'({d, 1'b0} + `VFD_DUTY_STEP0);
    end
  endfunction

  // Loop holds characters 0..N; digit k beyond the loop shows character k+1
  function automatic logic [3:0] char_of(input logic [3:0] k, input logic [3:0] start,
                                         input logic [2:0] len);
    logic [3:0] n;
    logic [4:0] s;
    n = 4'({1'b0, len} + `VFD_LEN_BASE);
    s = 5'(start) + 5'(k);
    if (k >= n) begin
      s = 5'(k) + `VFD_ADDR_STEP;
    end else begin
      // Two folds cover a start the host left above N
      if (s > 5'(n)) begin
        s = 5'(s - 5'(n) - `VFD_ADDR_STEP);
      end
      if (s > 5'(n)) begin
        s = 5'(s - 5'(n) - `VFD_ADDR_STEP);
      end
    end
    if (s > `VFD_CHAR_LAST) begin
      s = `VFD_CHAR_LAST;
    end
    char_of = s[3:0];
  endfunction

  vfd_word_fifo #(
    .WIDTH($bits(vfd_scan_pkg::word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_data(st_r.pend),
    .in_valid(st_r.pend_v),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(osc_tick)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic [3:0] ch;
    logic active;
    logic [7:0] word;
    ch = char_of(st_r.digit, st_r.start, st_r.ctl.len);
    active = st_r.slot < duty_units(st_r.ctl.duty);
    word = {st_r.sh[6:0], st_r.f.si};
    st_nxt = st_r;

    // Pin sampling: a change counts once the second and third flops agree
    st_nxt.s1 = pins_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.f = (st_r.f & (st_r.s2 ^ st_r.s3)) | (st_r.s3 & ~(st_r.s2 ^ st_r.s3));
    st_nxt.fp = st_r.f;

    // Serial receiver
    if (st_r.pend_v && fifo_in_ready) begin
      st_nxt.pend_v = 1'b0;
    end
    if (st_r.f.cs_n != st_r.fp.cs_n) begin
      // A partial word is dropped when the frame opens or closes
      st_nxt.bits = '0;
      st_nxt.first = 1'b1;
    end else if (!st_r.f.cs_n && st_r.f.sck && !st_r.fp.sck) begin
      st_nxt.sh = word;
      st_nxt.bits = 3'(st_r.bits + 1'b1);
      if (st_r.bits == `VFD_WORD_LAST_BIT) begin
        st_nxt.first = 1'b0;
        if (st_nxt.pend_v) begin
          // The pin side cannot be stalled, so a word meeting a full path is lost
          st_nxt.overrun = 1'b1;
        end else begin
          st_nxt.pend = '{first: st_r.first, data: word};
          st_nxt.pend_v = 1'b1;
        end
      end
    end

    // Word decoder
    if (pop && fifo_out.first) begin
      st_nxt.mode = vfd_scan_pkg::MODE_IGNORE;
      if (fifo_out.data[`VFD_CMD1_BIT]) begin
        st_nxt.ctl = fifo_out.data[`VFD_CTL_HI:0];
      end else if (fifo_out.data[`VFD_SEL_HI:`VFD_SEL_LO] == `VFD_SEL_ADDR) begin
        st_nxt.addr = fifo_out.data[`VFD_ADDR_HI:0];
        st_nxt.mode = vfd_scan_pkg::MODE_DATA;
      end else begin
        st_nxt.start = fifo_out.data[`VFD_START_HI:0];
      end
    end else if (pop && st_r.mode == vfd_scan_pkg::MODE_DATA) begin
      if (st_r.addr <= `VFD_ADDR_LAST_USED) begin
        st_nxt.ram[st_r.addr] = fifo_out.data;
      end
      st_nxt.addr = 5'(st_r.addr + `VFD_ADDR_STEP);
    end

    // Scan timing
    if (osc_tick) begin
      st_nxt.unit = 5'(st_r.unit + 1'b1);
      if (st_r.unit == 5'(`VFD_BLANK_OSC_PERIODS - 1)) begin
        st_nxt.unit = '0;
        st_nxt.slot = 4'(st_r.slot + 1'b1);
        if (st_r.slot == 4'(`VFD_UNITS_PER_DIGIT - 1)) begin
          st_nxt.slot = '0;
          st_nxt.digit = (st_r.digit == `VFD_DIGIT_LAST) ? '0 : 4'(st_r.digit + 1'b1);
        end
      end
    end

    // Outputs; segments keep running while the display is off
    st_nxt.seg = active ? {st_r.ram[{ch, 1'b1}], st_r.ram[{ch, 1'b0}]} : '0;
    st_nxt.dig = (active && st_r.ctl.on) ? 14'(14'h1 << st_r.digit) : '0;

    // Pin reset reaches command registers and frame mode only
    if (!st_r.f.reset_n || !rst_n) begin
      st_nxt.ctl = '{duty: `VFD_DUTY_RST, on: `VFD_ON_RST, len: `VFD_LEN_RST};
      st_nxt.start = `VFD_START_RST;
      st_nxt.mode = vfd_scan_pkg::MODE_IGNORE;
    end
    if (!rst_n) begin
      // Sampled pins restart at their idle levels so no false edge follows reset
      st_nxt.s1 = `VFD_PINS_RST;
      st_nxt.s2 = `VFD_PINS_RST;
      st_nxt.s3 = `VFD_PINS_RST;
      st_nxt.f = `VFD_PINS_RST;
      st_nxt.fp = `VFD_PINS_RST;
      st_nxt.sh = '0;
      st_nxt.bits = '0;
      st_nxt.first = 1'b1;
      st_nxt.pend = '0;
      st_nxt.pend_v = 1'b0;
      st_nxt.addr = '0;
      st_nxt.ram = st_r.ram;
      st_nxt.unit = '0;
      st_nxt.slot = '0;
      st_nxt.digit = '0;
      st_nxt.seg = '0;
      st_nxt.dig = '0;
      st_nxt.overrun = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    st_r <= st_nxt;
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  addr_load_a: assert property (
    pop && fifo_out.first && fifo_out.data[`VFD_SEL_HI:`VFD_SEL_LO] == `VFD_SEL_ADDR
    && st_r.f.reset_n |=> st_r.addr == $past(fifo_out.data[4:0])
      && st_r.mode == vfd_scan_pkg::MODE_DATA)
    else $error("address word did not load the counter");

  addr_step_a: assert property (
    pop && !fifo_out.first && st_r.mode == vfd_scan_pkg::MODE_DATA
    |=> st_r.addr == 5'($past(st_r.addr) + 5'h01))
    else $error("address counter did not step by one");

  data_store_a: assert property (
    pop && !fifo_out.first && st_r.mode == vfd_scan_pkg::MODE_DATA
    && st_r.addr <= `VFD_ADDR_LAST_USED
    |=> st_r.ram[$past(st_r.addr)] == $past(fifo_out.data))
    else $error("display data not stored at the counter");

  high_drop_a: assert property (
    pop && st_r.addr > `VFD_ADDR_LAST_USED |=> st_r.ram == $past(st_r.ram))
    else $error("data for a missing address changed the memory");

  ctl_load_a: assert property (
    pop && fifo_out.first && fifo_out.data[7] && st_r.f.reset_n
    |=> st_r.ctl == $past(fifo_out.data[6:0]))
    else $error("control word not stored");

  start_load_a: assert property (
    pop && fifo_out.first && fifo_out.data[7:6] == 2'h1 && st_r.f.reset_n
    |=> st_r.start == $past(fifo_out.data[3:0]))
    else $error("start character not stored");

  pin_reset_a: assert property (
    !st_r.f.reset_n |=> st_r.start == 4'h1 && st_r.ctl.on == 1'b0
      && st_r.ctl.duty == 3'h0 && st_r.mode == vfd_scan_pkg::MODE_IGNORE)
    else $error("pin reset left command registers set");

  cmd_ignore_a: assert property (
    pop && !fifo_out.first && st_r.mode == vfd_scan_pkg::MODE_IGNORE
    |=> st_r.ram == $past(st_r.ram) && $stable(st_r.addr))
    else $error("word after a command word took effect");

  off_dark_a: assert property (
    !st_r.ctl.on |=> digit_outputs == 14'h0)
    else $error("digit driven while display off");

  one_digit_a: assert property (
    $onehot0(digit_outputs))
    else $error("more than one digit active");

  duty_window_a: assert property (
    st_r.ctl.on && st_r.slot < duty_units(st_r.ctl.duty)
    |=> digit_outputs == 14'(14'h1 << $past(st_r.digit)))
    else $error("digit not active inside its duty window");

  blank_units_a: assert property (
    osc_tick && st_r.unit != 5'h1f |=> $stable(st_r.slot))
    else $error("blanking unit ended early");

  // --------------------------------------------------------------------------
  // Scan timing checks
  // --------------------------------------------------------------------------
  unit_step_a: assert property (
    osc_tick && st_r.unit != 5'h1f |=> st_r.unit == 5'($past(st_r.unit) + 5'h01))
    else $error("blanking unit count did not step");

  slot_step_a: assert property (
    osc_tick && st_r.unit == 5'h1f && st_r.slot != 4'hf
    |=> st_r.slot == 4'($past(st_r.slot) + 4'h1))
    else $error("blanking unit did not close after its last tick");

  digit_step_a: assert property (
    osc_tick && st_r.unit == 5'h1f && st_r.slot == 4'hf && st_r.digit != 4'hd
    |=> st_r.digit == 4'($past(st_r.digit) + 4'h1))
    else $error("digit period did not pass to the next digit");

  digit_wrap_a: assert property (
    osc_tick && st_r.unit == 5'h1f && st_r.slot == 4'hf && st_r.digit == 4'hd
    |=> st_r.digit == 4'h0)
    else $error("scan did not return to the first digit");

  dark_gap_a: assert property (
    st_r.slot == 4'hf |=> digit_outputs == 14'h0 && segment_outputs == 16'h0)
    else $error("last blanking unit of a digit was not dark");

  duty_full_a: assert property (
    st_r.ctl.on && st_r.ctl.duty == 3'h7 && st_r.slot == 4'he |=> digit_outputs != 14'h0)
    else $error("full duty digit dark before its last unit");

  duty_min_a: assert property (
    st_r.ctl.duty == 3'h0 && st_r.slot == 4'h2 |=> digit_outputs == 14'h0)
    else $error("shortest duty digit still active");

  // --------------------------------------------------------------------------
  // Word path checks
  // --------------------------------------------------------------------------
  select_gate_a: assert property (
    st_r.f.cs_n && !st_r.pend_v |=> !st_r.pend_v)
    else $error("word taken while the select pin was high");

  whole_word_a: assert property (
    !st_r.pend_v && st_r.bits != `VFD_WORD_LAST_BIT |=> !st_r.pend_v)
    else $error("word taken before its eighth bit");

  tick_only_a: assert property (
    !osc_tick && st_r.f.reset_n |=> $stable(st_r.ctl) && $stable(st_r.start))
    else $error("command register changed between oscillator ticks");

  addr_wrap_a: assert property (
    pop && !fifo_out.first && st_r.mode == vfd_scan_pkg::MODE_DATA && st_r.addr == 5'h1f
    |=> st_r.addr == 5'h00)
    else $error("address counter did not wrap to zero");

  pin_keep_a: assert property (
    !st_r.f.reset_n && !pop |=> st_r.ram == $past(st_r.ram))
    else $error("pin reset changed the display memory");

  overrun_hold_a: assert property (
    rx_overrun |=> rx_overrun)
    else $error("overrun flag dropped without reset");

  data_write_c: cover property (pop && !fifo_out.first && st_r.mode == vfd_scan_pkg::MODE_DATA);
  addr_wrap_c: cover property (pop && st_r.addr == 5'h1f ##1 st_r.addr == 5'h00);
  fifo_full_c: cover property (!fifo_in_ready);
  last_digit_c: cover property (digit_outputs[13]);
  pin_reset_c: cover property (!st_r.f.reset_n);
endmodule

// ===== core/vfd_scan_defs.svh
// Purpose: Constants for the serial-loaded VFD scan controller.
// Assumes: Included by bare name; definitions only.
// Notes: Field positions follow the first-word layout of the serial frame.
// Function
// - First word 00xxxxxx loads its low five bits into the RAM address counter.
// - Later words store display data at the counter, then the counter increments.
// - Host loads 00h..1Dh only; increment still runs through 1Eh, 1Fh, wraps to 00h.
// - Data for address 1Eh or 1Fh is dropped; the counter still advances.
// - Thirty bytes; character n low segments at 2n, high segments at 2n+1.
// - First word 1xxxxxxx stores its low seven bits as scan control.
// - Duty codes 0..6 give 2/16..14/16 in steps of two; code 7 gives 15/16.
// - Display bit 1 is on; off keeps segment waveforms but holds digits inactive.
// - Loop length code plus seven gives N, seven to fourteen digits.
// - Reset sets scan control to duty 2/16 with display off.
// - First word 01xxxxxx stores its low four bits as the start character.
// - Start character 0..14 shows on the first digit; code 15 is prohibited. The code shows a start above N as start-N-1 instead.
// - Reset sets the start character to 1.
// - Reset pin low reinitialises both command registers; display RAM is kept.
// - Loop digit k shows start plus k, wrapping past the last loop character.
// - Digits at or beyond N always show their own fixed character.
// - One blanking unit lasts 32 oscillator periods.
// - A digit period is 16 blanking units; a scan steps all 14 digits.
// - Sixteen segments carry the current pattern while one of fourteen digits is active.
// - Serial input is taken only while the select pin is low.
// - Words are eight bits, first bit most significant; only whole words decode.
// - Data bits are sampled on serial clock rising edges; eight bits make a word.
// - After a command first word, the rest of the frame is ignored.
`ifndef VFD_SCAN_DEFS_SVH
`define VFD_SCAN_DEFS_SVH

`define VFD_WORD_MSB 7
`define VFD_WORD_LAST_BIT 3'h7
`define VFD_SEL_HI 7
`define VFD_SEL_LO 6
`define VFD_SEL_ADDR 2'h0
`define VFD_SEL_START 2'h1
`define VFD_CMD1_BIT 7
`define VFD_ADDR_HI 4
`define VFD_CTL_HI 6
`define VFD_START_HI 3
`define VFD_ADDR_LAST_USED 5'h1d
`define VFD_ADDR_STEP 5'h01
`define VFD_CHAR_LAST 5'h0e
`define VFD_RAM_BYTES 30
`define VFD_DIGIT_LAST 4'hd

`define VFD_DUTY_RST 3'h0
`define VFD_ON_RST 1'h0
`define VFD_LEN_RST 3'h7
`define VFD_START_RST 4'h1
`define VFD_LEN_BASE 4'h7
`define VFD_DUTY_FULL 3'h7
`define VFD_DUTY_FULL_UNITS 4'hf
`define VFD_DUTY_STEP0 4'h2

`define VFD_BLANK_OSC_PERIODS 32
`define VFD_UNITS_PER_DIGIT 16
`define VFD_PINS_RST 5'h15
`define VFD_FIFO_DEPTH 8

`endif

// ===== core/vfd_scan_pkg.sv
// Purpose: Types shared by the VFD scan controller.
// Assumes: Widths match the constants header.
// Notes: Nothing here is imported; users write the package name.
package vfd_scan_pkg;

  // Order fixes the reset pattern in the constants header
  typedef struct packed {
    logic reset_n;
    logic osc;
    logic sck;
    logic si;
    logic cs_n;
  } pins_t;

  typedef struct packed {
    logic first;
    logic [7:0] data;
  } word_t;

  typedef struct packed {
    logic [2:0] duty;
    logic on;
    logic [2:0] len;
  } scan_ctl_t;

  typedef enum logic {MODE_DATA, MODE_IGNORE} frame_mode_t;

  typedef struct packed {
    pins_t s1;
    pins_t s2;
    pins_t s3;
    pins_t f;
    pins_t fp;
    logic [7:0] sh;
    logic [2:0] bits;
    logic first;
    word_t pend;
    logic pend_v;
    frame_mode_t mode;
    logic [4:0] addr;
    logic [29:0][7:0] ram;
    scan_ctl_t ctl;
    logic [3:0] start;
    logic [4:0] unit;
    logic [3:0] slot;
    logic [3:0] digit;
    logic [15:0] seg;
    logic [13:0] dig;
    logic overrun;
  } vfd_st_t;

endpackage

// ===== verification/test_vfd_scan_controller.sv
// Purpose: Self-checking bench for the VFD scan controller.
// Assumes: Oscillator pin toggles every 2 core cycles; word FIFO depth 2.
// Notes: Scan checks follow digits as they come, so no wait spans a whole scan.
`timescale 1ns/1ps
`include "vfd_scan_defs.svh"

module test_vfd_scan_controller;
  localparam int UNIT_CYC = `VFD_BLANK_OSC_PERIODS * 4;
  logic core_clk;
  logic rst_n;
  logic reset_n_pin;
  logic osc_in_pin;
  logic osc_run;
  logic select_n_pin;
  logic sck_pin;
  logic si_pin;
  logic [15:0] segment_outputs;
  logic [13:0] digit_outputs;
  logic rx_overrun;
  logic [7:0] mem [0:29];
  logic [7:0] txbuf [0:39];
  logic [15:0] seg_seen;
  logic [13:0] mask_seen;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int run;
  int k;
  int prev;

  vfd_scan_controller #(.FIFO_DEPTH(2)) dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .reset_n_pin(reset_n_pin),
    .select_n_pin(select_n_pin),
    .sck_pin(sck_pin),
    .si_pin(si_pin),
    .osc_in_pin(osc_in_pin),
    .segment_outputs(segment_outputs),
    .digit_outputs(digit_outputs),
    .rx_overrun(rx_overrun)
  );

  vfd_host_model host (
    .select_n_pin(select_n_pin),
    .sck_pin(sck_pin),
    .si_pin(si_pin)
  );

  // ----------------------------------------------------------------------
  // Clocks and timeout
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Oscillator stops while osc_run is low so the word path backs up
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (osc_run && cycles[0]) osc_in_pin <= #1 ~osc_in_pin;
    if (cycles == 99000) begin
      bad_count++;
      close_out();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic frame(input logic [7:0] first, input int count);
    host.open_frame();
    host.shift_bits(first, 8);
    for (int i = 0; i < count; i++) host.shift_bits(txbuf[i], 8);
    host.close_frame();
    step(1);
  endtask

  task automatic watch(input int n);
    seg_seen = 16'h0;
    mask_seen = 14'h0;
    repeat (n) begin
      @(negedge core_clk);
      seg_seen |= segment_outputs;
      mask_seen |= digit_outputs;
    end
  endtask

  // Waits out the current pulse, then measures the next whole one
  task automatic grab();
    int n;
    n = 0;
    run = 0;
    while (digit_outputs !== 14'h0 && n < 9000) begin
      @(negedge core_clk);
      n++;
    end
    while (digit_outputs === 14'h0 && n < 9000) begin
      @(negedge core_clk);
      n++;
    end
    mask_seen = digit_outputs;
    seg_seen = segment_outputs;
    while (digit_outputs === mask_seen && n < 9000) begin
      @(negedge core_clk);
      run++;
      n++;
    end
    check("digit wait", 16'(n < 9000), 16'h1);
    check("one digit", 16'($onehot(mask_seen)), 16'h1);
    k = 0;
    for (int i = 0; i < 14; i++) if (mask_seen[i]) k = i;
  endtask

  function automatic int units(input int code);
    return (code == 7) ? 15 : 2 * (code + 1);
  endfunction

  function automatic logic [15:0] char_seg(input int c);
    return {mem[2 * c + 1], mem[2 * c]};
  endfunction

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    reset_n_pin = 1'b1;
    osc_in_pin = 1'b0;
    osc_run = 1'b1;
    step(3);
    check("segments in reset", segment_outputs, 16'h0);
    check("digits in reset", 16'(digit_outputs), 16'h0);
    rst_n = 1'b1;
    check("overrun", 16'(rx_overrun), 16'h0);
    $display("test reset done");
    // 33 bytes from 00h: two land on 1Eh/1Fh, the last wraps to 00h
    for (int i = 0; i < 33; i++) txbuf[i] = 8'(i * 29 + 53);
    for (int i = 0; i < 30; i++) mem[i] = txbuf[i];
    mem[0] = txbuf[32];
    frame(8'h00, 33);
    host.open_frame();
    host.shift_bits(8'h02, 8);
    host.shift_bits(8'hc3, 4);
    host.close_frame();
    watch(2500);
    check("digits while off", 16'(mask_seen), 16'h0);
    check("segments while off", 16'(seg_seen != 16'h0), 16'h1);
    $display("test load done");
    txbuf[0] = 8'h5a;
    frame(8'hfc, 1);
    frame(8'h43, 1);
    for (int d = 0; d < 14; d++) begin
      grab();
      check("segments", seg_seen, char_seg(k < 11 ? (3 + k) % 12 : k + 1));
      check("full duty run", 16'(run), 16'(15 * UNIT_CYC));
      if (d > 0) check("digit order", 16'(k), 16'((prev + 1) % 14));
      prev = k;
    end
    $display("test scan done");
    for (int c = 0; c < 7; c++) begin
      frame(8'h8c | 8'(c << 4), 0);
      grab();
      check("duty run", 16'(run), 16'(units(c) * UNIT_CYC));
    end
    $display("test duty done");
    step(1);
    reset_n_pin = 1'b0;
    step(20);
    reset_n_pin = 1'b1;
    step(20);
    watch(2200);
    check("digits after pin reset", 16'(mask_seen), 16'h0);
    frame(8'h8f, 0);
    grab();
    check("start after pin reset", seg_seen, char_seg((1 + k) % 15));
    check("reset duty", 16'(run), 16'(2 * UNIT_CYC));
    $display("test pin reset done");
    step(1);
    osc_run = 1'b0;
    for (int i = 0; i < 6; i++) txbuf[i] = 8'h00;
    frame(8'h00, 6);
    check("overrun set", 16'(rx_overrun), 16'h1);
    osc_run = 1'b1;
    step(200);
    check("overrun held", 16'(rx_overrun), 16'h1);
    $display("test overrun done");
    close_out();
  end
endmodule

// ===== verification/vfd_host_model.sv
// Purpose: Host side of the serial write port; it sends words bit by bit.
// Assumes: Serial clock period 125 ns, idle high, still outside frames.
// Notes: The data line flips to the inverse of its last bit once a frame closes,
//   so a device that samples it late sees a wrong value rather than a lucky one.
`timescale 1ns/1ps

module vfd_host_model (
  output logic select_n_pin,
  output logic sck_pin,
  output logic si_pin
);
  initial begin
    select_n_pin = 1'b1;
    sck_pin = 1'b1;
    si_pin = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Frame tasks
  // ----------------------------------------------------------------------
  task automatic open_frame();
    select_n_pin = 1'b0;
    #200;
  endtask

  // Data changes while the clock is low, so it is settled at the rise
  task automatic shift_bits(input logic [7:0] value, input int count);
    for (int i = 7; i > 7 - count; i--) begin
      sck_pin = 1'b0;
      si_pin = value[i];
      #62.5;
      sck_pin = 1'b1;
      #62.5;
    end
  endtask

  task automatic close_frame();
    #200;
    select_n_pin = 1'b1;
    si_pin = ~si_pin;
    #400;
  endtask
endmodule
